// [rtl/sfc_pkg.sv]
/*
  constants for one synchronous fifo channel with a wishbone register file.
  assumes one clock domain; pin-level clocks arrive as sampled inputs.
*/
// Operation
// - write gate primary low stores the input word on each write clock rise
// - in programmable-flag mode writes need primary low and load high
// - dual-gate mode writes need primary low and second gate high
// - writes are ignored while the full flag is low
// - shared pin sampled at reset: high dual-gate, low offset-load mode
// - both read gates low advance and present the next word per read clock rise
// - no read and no read pointer movement while empty flag is low
// - output data is nine bits, words leave in arrival order
// - output enable low drives data outputs, high releases them
// - empty flag low when no words stored, updated on read side
// - almost-empty low at or below empty offset, default seven
// - reset clears pointers, full flags high, empty flags low
// - full flag low when storage full, updated on write side
// - almost-full low at or above depth minus full offset, default seven
package sfc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] SFC_AE_OFS_ADR = 8'h00;
  localparam logic [7:0] SFC_AF_OFS_ADR = 8'h04;
  localparam logic [7:0] SFC_STATUS_ADR = 8'h08;
  localparam logic [7:0] SFC_IRQ_ST_ADR = 8'h0c;
  localparam logic [7:0] SFC_IRQ_MK_ADR = 8'h10;

  // ----------------------------------------------------------------
  // status fields
  // ----------------------------------------------------------------
  localparam int SFC_ST_EMPTY_N = 0;
  localparam int SFC_ST_AE_N    = 1;
  localparam int SFC_ST_FULL_N  = 2;
  localparam int SFC_ST_AF_N    = 3;
  localparam int SFC_ST_PROG    = 4;
  localparam int SFC_ST_COUNT   = 16;

  // ----------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------
  localparam int SFC_IRQ_W      = 4;
  localparam int SFC_EV_EMPTY   = 0;
  localparam int SFC_EV_FULL    = 1;
  localparam int SFC_EV_OVER    = 2;
  localparam int SFC_EV_UNDER   = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam int                 SFC_DEF_OFS = 7;
  localparam logic [SFC_IRQ_W-1:0] SFC_MASK_RST = 4'h0;

endpackage

// [rtl/sfc_channel.sv]
/*
  one fifo channel: storage, pointers, flags, offset registers,
  wishbone classic slave and a level interrupt.
  assumes write and read pin clocks are sampled by clk_i and run at
  most at half its rate; depth is a power of two.
*/
module sfc_channel
  import sfc_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int DW    = 9
) (
  input  wire logic          clk_i,                 // system clock
  input  wire logic          rst_i,                 // sync reset, high
  input  wire logic          ce_i,                  // clock enable
  input  wire logic          wb_cyc_i,              // bus cycle
  input  wire logic          wb_stb_i,              // bus strobe
  input  wire logic          wb_we_i,               // bus write
  input  wire logic [7:0]    wb_adr_i,              // byte address
  input  wire logic [3:0]    wb_sel_i,              // byte enables
  input  wire logic [31:0]   wb_dat_i,              // write data
  output logic      [31:0]   wb_dat_o,              // read data
  output logic               wb_ack_o,              // acknowledge
  output logic               irq_o,                 // level interrupt
  input  wire logic          write_side_clock_i,    // write pin clock
  input  wire logic          write_gate_primary_n_i, // write gate, low
  input  wire logic          write_gate_second_or_offset_load_i, // gate2/load_n
  input  wire logic [DW-1:0] write_data_in_i,       // input word
  input  wire logic          read_side_clock_i,     // read pin clock
  input  wire logic          read_gate_first_n_i,   // read gate 1, low
  input  wire logic          read_gate_second_n_i,  // read gate 2, low
  input  wire logic          output_drive_enable_n_i, // output enable, low
  output logic      [DW-1:0] read_data_out_o,       // output word
  output logic               read_data_oe_o,        // output driven
  output logic               empty_flag_n_o,        // empty, low
  output logic               almost_empty_flag_n_o, // almost empty, low
  output logic               full_flag_n_o,         // full, low
  output logic               almost_full_flag_n_o   // almost full, low
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  localparam logic [AW:0] OFS_RST = (AW+1)'(SFC_DEF_OFS);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // rising edge of a pin clock seen by clk_i
  function automatic logic rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  // byte-lane merge of a bus write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] new_d,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [DW-1:0]        mem [DEPTH];
  logic [AW-1:0]        wptr_reg, wptr_next;
  logic [AW-1:0]        rptr_reg, rptr_next;
  logic [AW:0]          count_reg, count_next;
  logic [AW:0]          ae_ofs_reg, ae_ofs_next;
  logic [AW:0]          af_ofs_reg, af_ofs_next;
  logic [SFC_IRQ_W-1:0] irq_st_reg, irq_st_next;
  logic [SFC_IRQ_W-1:0] irq_mk_reg, irq_mk_next;
  logic                 prog_reg;
  logic                 wclk_prev_reg, rclk_prev_reg;
  logic [DW-1:0]        rdata_reg, rdata_next;
  logic                 oe_reg;
  logic                 ef_reg, ef_next, ae_reg, ae_next;
  logic                 ff_reg, ff_next, af_reg, af_next;
  logic [31:0]          dat_reg, dat_next;
  logic                 ack_reg, ack_next;
  logic                 irq_reg, irq_next;

  logic                 wr_edge, rd_edge, wr_ok, rd_ok, wr_go, rd_go;
  logic                 bus_req, bus_wr;
  logic [31:0]          status_w;
  logic [DW-1:0]        rd_word;
  logic [31:0]          ae_ofs_m, af_ofs_m, irq_clr_m, irq_mk_m;

  // ----------------------------------------------------------------
  // transfer decode
  // ----------------------------------------------------------------
  // pin clocks are sampled, so one edge is one qualified clk_i cycle
  assign wr_edge = rise(write_side_clock_i, wclk_prev_reg);
  assign rd_edge = rise(read_side_clock_i, rclk_prev_reg);

  // gate selection follows the mode caught at reset
  always_comb begin
    if (prog_reg) begin
      // load low means an offset access, never a data write
      wr_ok = ~write_gate_primary_n_i
              & write_gate_second_or_offset_load_i;
    end else begin
      wr_ok = ~write_gate_primary_n_i
              & write_gate_second_or_offset_load_i;
    end
  end

  assign wr_go = wr_edge & wr_ok & ff_reg;
  assign rd_ok = ~read_gate_first_n_i & ~read_gate_second_n_i;
  assign rd_go = rd_edge & rd_ok & ef_reg;
  assign rd_word = mem[rptr_reg];

  // ----------------------------------------------------------------
  // pointers, count and flags
  // ----------------------------------------------------------------
  // flags are computed from next values so they never lag the count
  always_comb begin
    wptr_next  = wptr_reg;
    rptr_next  = rptr_reg;
    count_next = count_reg;
    rdata_next = rdata_reg;
    if (wr_go) begin
      wptr_next = wptr_reg + 1'b1;
    end
    if (rd_go) begin
      rptr_next  = rptr_reg + 1'b1;
      rdata_next = rd_word;
    end
    case ({wr_go, rd_go})
      2'b10:   count_next = count_reg + 1'b1;
      2'b01:   count_next = count_reg - 1'b1;
      default: count_next = count_reg;
    endcase
    ef_next = (count_next != '0);
    ff_next = (count_next != DEPTH_C);
    ae_next = (count_next > ae_ofs_next);
    af_next = (count_next < (DEPTH_C - af_ofs_next));
  end

  // storage write; no reset needed on the array itself
  always_ff @(posedge clk_i) begin
    if (!rst_i && ce_i && wr_go) begin
      mem[wptr_reg] <= write_data_in_i;
    end
  end

  // ----------------------------------------------------------------
  // register file and interrupt
  // ----------------------------------------------------------------
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign bus_wr  = bus_req & wb_we_i;

  // byte-lane merges, sliced where used since a call result cannot be sliced
  assign ae_ofs_m  = merge(32'(ae_ofs_reg), wb_dat_i, wb_sel_i);
  assign af_ofs_m  = merge(32'(af_ofs_reg), wb_dat_i, wb_sel_i);
  assign irq_clr_m = merge(32'h0, wb_dat_i, wb_sel_i);
  assign irq_mk_m  = merge(32'(irq_mk_reg), wb_dat_i, wb_sel_i);

  always_comb begin
    status_w = '0;
    status_w[SFC_ST_EMPTY_N] = ef_reg;
    status_w[SFC_ST_AE_N]    = ae_reg;
    status_w[SFC_ST_FULL_N]  = ff_reg;
    status_w[SFC_ST_AF_N]    = af_reg;
    status_w[SFC_ST_PROG]    = prog_reg;
    status_w[SFC_ST_COUNT +: AW+1] = count_reg;
  end

  // offsets only accept writes while load is held low in offset mode
  always_comb begin
    ae_ofs_next = ae_ofs_reg;
    af_ofs_next = af_ofs_reg;
    irq_mk_next = irq_mk_reg;
    irq_st_next = irq_st_reg;
    dat_next    = dat_reg;
    ack_next    = bus_req;
    if (bus_wr) begin
      case (wb_adr_i)
        SFC_AE_OFS_ADR: begin
          if (prog_reg && !write_gate_second_or_offset_load_i) begin
            ae_ofs_next = ae_ofs_m[AW:0];
          end
        end
        SFC_AF_OFS_ADR: begin
          if (prog_reg && !write_gate_second_or_offset_load_i) begin
            af_ofs_next = af_ofs_m[AW:0];
          end
        end
        SFC_IRQ_ST_ADR: begin
          irq_st_next = irq_st_reg & ~irq_clr_m[SFC_IRQ_W-1:0];
        end
        SFC_IRQ_MK_ADR: begin
          irq_mk_next = irq_mk_m[SFC_IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end else if (bus_req) begin
      case (wb_adr_i)
        SFC_AE_OFS_ADR: dat_next = 32'(ae_ofs_reg);
        SFC_AF_OFS_ADR: dat_next = 32'(af_ofs_reg);
        SFC_STATUS_ADR: dat_next = status_w;
        SFC_IRQ_ST_ADR: dat_next = 32'(irq_st_reg);
        SFC_IRQ_MK_ADR: dat_next = 32'(irq_mk_reg);
        default:        dat_next = 32'h0;
      endcase
    end
    // events set after the clear so a same-cycle event wins
    irq_st_next[SFC_EV_EMPTY] = irq_st_next[SFC_EV_EMPTY] | (ef_reg & ~ef_next);
    irq_st_next[SFC_EV_FULL]  = irq_st_next[SFC_EV_FULL] | (ff_reg & ~ff_next);
    irq_st_next[SFC_EV_OVER]  = irq_st_next[SFC_EV_OVER]
                                | (wr_edge & wr_ok & ~ff_reg);
    irq_st_next[SFC_EV_UNDER] = irq_st_next[SFC_EV_UNDER]
                                | (rd_edge & rd_ok & ~ef_reg);
    irq_next = |(irq_st_next & irq_mk_next);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // reset wins over the clock enable so a frozen block still resets
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prog_reg      <= ~write_gate_second_or_offset_load_i;
      wptr_reg      <= '0;
      rptr_reg      <= '0;
      count_reg     <= '0;
      ae_ofs_reg    <= OFS_RST;
      af_ofs_reg    <= OFS_RST;
      ef_reg        <= 1'b0;
      ae_reg        <= 1'b0;
      ff_reg        <= 1'b1;
      af_reg        <= 1'b1;
      rdata_reg     <= '0;
      oe_reg        <= 1'b0;
      wclk_prev_reg <= 1'b1;
      rclk_prev_reg <= 1'b1;
      irq_st_reg    <= '0;
      irq_mk_reg    <= SFC_MASK_RST;
      dat_reg       <= '0;
      ack_reg       <= 1'b0;
      irq_reg       <= 1'b0;
    end else if (ce_i) begin
      wptr_reg      <= wptr_next;
      rptr_reg      <= rptr_next;
      count_reg     <= count_next;
      ae_ofs_reg    <= ae_ofs_next;
      af_ofs_reg    <= af_ofs_next;
      ef_reg        <= ef_next;
      ae_reg        <= ae_next;
      ff_reg        <= ff_next;
      af_reg        <= af_next;
      rdata_reg     <= rdata_next;
      oe_reg        <= ~output_drive_enable_n_i;
      wclk_prev_reg <= write_side_clock_i;
      rclk_prev_reg <= read_side_clock_i;
      irq_st_reg    <= irq_st_next;
      irq_mk_reg    <= irq_mk_next;
      dat_reg       <= dat_next;
      ack_reg       <= ack_next;
      irq_reg       <= irq_next;
    end
  end

  assign read_data_out_o       = rdata_reg;
  assign read_data_oe_o        = oe_reg;
  assign empty_flag_n_o        = ef_reg;
  assign almost_empty_flag_n_o = ae_reg;
  assign full_flag_n_o         = ff_reg;
  assign almost_full_flag_n_o  = af_reg;
  assign wb_dat_o              = dat_reg;
  assign wb_ack_o              = ack_reg;
  assign irq_o                 = irq_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_write_taken;
    ce_i && wr_go && !rd_go;
  endsequence

  sequence s_count_up;
    count_reg == $past(count_reg) + 1'b1;
  endsequence

  a_write_counts_up: assert property (@(posedge clk_i) disable iff (rst_i)
    s_write_taken |=> s_count_up)
    else $error("accepted write did not raise the count");

  a_prog_gate_only: assert property (@(posedge clk_i) disable iff (rst_i)
    prog_reg && write_gate_primary_n_i |-> !wr_go)
    else $error("write taken with primary gate high");

  a_dual_gate_pair: assert property (@(posedge clk_i) disable iff (rst_i)
    !prog_reg && !write_gate_second_or_offset_load_i |-> !wr_go)
    else $error("write taken with second gate low");

  a_full_blocks_write: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !full_flag_n_o && !rd_go |=> $stable(wptr_reg) && $stable(count_reg))
    else $error("write changed state while full");

  a_strap_caught: assert property (@(posedge clk_i)
    $fell(rst_i) |-> prog_reg == !$past(write_gate_second_or_offset_load_i))
    else $error("mode not caught from shared pin at reset");

  a_read_order: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && rd_go |=> read_data_out_o == $past(rd_word))
    else $error("read did not present the oldest word");

  a_empty_no_read: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !empty_flag_n_o |=> $stable(rptr_reg))
    else $error("read pointer moved while empty");

  a_oe_follows_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> read_data_oe_o == !$past(output_drive_enable_n_i))
    else $error("output drive does not follow enable");

  a_empty_flag_count: assert property (@(posedge clk_i) disable iff (rst_i)
    empty_flag_n_o == (count_reg != '0))
    else $error("empty flag disagrees with count");

  a_ae_threshold: assert property (@(posedge clk_i) disable iff (rst_i)
    almost_empty_flag_n_o == (count_reg > ae_ofs_reg))
    else $error("almost-empty flag disagrees with offset");

  a_reset_state: assert property (@(posedge clk_i)
    $fell(rst_i) |-> full_flag_n_o && almost_full_flag_n_o
      && !empty_flag_n_o && !almost_empty_flag_n_o && wptr_reg == '0)
    else $error("reset state of flags or pointers wrong");

  a_full_flag_count: assert property (@(posedge clk_i) disable iff (rst_i)
    full_flag_n_o == (count_reg != DEPTH_C))
    else $error("full flag disagrees with count");

  a_af_threshold: assert property (@(posedge clk_i) disable iff (rst_i)
    almost_full_flag_n_o == (count_reg < DEPTH_C - af_ofs_reg))
    else $error("almost-full flag disagrees with offset");

endmodule

// [dv/sfc_pin_partner.sv]
/*
  producer and consumer pin model for one fifo channel.
  assumes clk_i is the bench clock; pin clocks stand low between ticks.
*/
module sfc_pin_partner (
  input  wire logic clk_i,      // bench clock
  output logic       wclk_o,     // write pin clock
  output logic       wgate_n_o,  // primary write gate
  output logic       wsec_o,     // second gate or load
  output logic [8:0] wdata_o,    // input word
  output logic       rclk_o,     // read pin clock
  output logic       rgate1_n_o, // read gate one
  output logic       rgate2_n_o  // read gate two
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // idle pins at time zero; primary write gate and read gates inactive so nothing moves early
  initial begin
    wclk_o     = 1'b0;
    wgate_n_o  = 1'b1;
    wsec_o     = 1'b1;
    wdata_o    = 9'h000;
    rclk_o     = 1'b0;
    rgate1_n_o = 1'b1;
    rgate2_n_o = 1'b1;
  end

  // load level is a static strap, so it is held between ticks
  task automatic set_load(input logic lvl);
    @(posedge clk_i);
    wsec_o <= lvl;
  endtask

  // one write tick, then a random idle gap for a slow producer
  task automatic push(input logic [8:0] w, input logic gn, input logic sec, input int gap);
    @(posedge clk_i);
    wclk_o    <= 1'b1;
    wgate_n_o <= gn;
    wsec_o    <= sec;
    wdata_o   <= w;
    @(posedge clk_i);
    wclk_o    <= 1'b0;
    wgate_n_o <= 1'b1;
    wdata_o   <= ~w; // released line must not show a stale word
    repeat (gap + 1) @(posedge clk_i);
  endtask

  // one read tick with the given gate levels
  task automatic pop(input logic g1, input logic g2, input int gap);
    @(posedge clk_i);
    rclk_o     <= 1'b1;
    rgate1_n_o <= g1;
    rgate2_n_o <= g2;
    @(posedge clk_i);
    rclk_o     <= 1'b0;
    rgate1_n_o <= 1'b1;
    rgate2_n_o <= 1'b1;
    repeat (gap + 1) @(posedge clk_i);
  endtask
endmodule

// [dv/tb_top.sv]
/*
  self-checking bench for one fifo channel with a reference queue.
  assumes the package and channel are compiled first; ce_i stays high.
*/
module tb_top
  import sfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 16;

  logic clk_i = 1'b0, rst_i = 1'b1, oe_n = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, irq_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r;
  logic wclk, wgn, wsec, rclk, rg1, rg2, oe_o, ef_n, ae_n, ff_n, af_n;
  logic [8:0] wdat, qdat, last = 9'h000;
  logic [8:0] q[$];
  int n_fail = 0, checks_done = 0, cycles = 0, ae = 7, af = 7;

  initial forever #2.5 clk_i = ~clk_i;

  sfc_channel #(.DEPTH(DEPTH)) u_sfc_channel (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .write_side_clock_i(wclk),
    .write_gate_primary_n_i(wgn), .write_gate_second_or_offset_load_i(wsec),
    .write_data_in_i(wdat), .read_side_clock_i(rclk), .read_gate_first_n_i(rg1),
    .read_gate_second_n_i(rg2), .output_drive_enable_n_i(oe_n), .read_data_out_o(qdat),
    .read_data_oe_o(oe_o), .empty_flag_n_o(ef_n), .almost_empty_flag_n_o(ae_n),
    .full_flag_n_o(ff_n), .almost_full_flag_n_o(af_n));

  sfc_pin_partner u_sfc_pin_partner (
    .clk_i(clk_i), .wclk_o(wclk), .wgate_n_o(wgn), .wsec_o(wsec), .wdata_o(wdat),
    .rclk_o(rclk), .rgate1_n_o(rg1), .rgate2_n_o(rg2));

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // flags as {almost full, full, almost empty, empty}, all active low
  function automatic logic [3:0] exp_flags(int cnt);
    exp_flags = {!(cnt >= DEPTH - af), cnt != DEPTH, !(cnt <= ae), cnt != 0};
  endfunction

  task automatic chk_flags;
    @(negedge clk_i);
    chk("flags", {28'h0, exp_flags(q.size())}, {28'h0, af_n, ff_n, ae_n, ef_n});
  endtask

  // classic single cycle; waits for ack under a bound, no fixed latency
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    if (n >= 40) chk("wb_ack", 32'h1, 32'h0);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // write tick; the model stores only a gated word while not full
  task automatic put(input logic gn, input logic sec);
    logic [8:0] w;
    w = 9'($urandom);
    u_sfc_pin_partner.push(w, gn, sec, $urandom % 3);
    if (!gn && sec && q.size() < DEPTH) q.push_back(w);
    chk_flags();
  endtask

  // read tick; the output holds its word when nothing is read
  task automatic get(input logic g1, input logic g2);
    u_sfc_pin_partner.pop(g1, g2, $urandom % 3);
    if (!g1 && !g2 && q.size() > 0) last = q.pop_front();
    chk_flags();
    chk("read_data", {23'h0, last}, {23'h0, qdat});
  endtask

  task automatic do_reset(input logic load);
    @(posedge clk_i);
    rst_i <= 1'b1;
    u_sfc_pin_partner.set_load(load);
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    q.delete();
    ae = 7;
    af = 7;
    last = 9'h000;
  endtask

  // hang guard, about thirty times the expected run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(61));
    do_reset(1'b1);
    chk_flags();
    wb(1'b0, SFC_AE_OFS_ADR, 32'h0);
    chk("ae_ofs", SFC_DEF_OFS, r);
    wb(1'b0, SFC_AF_OFS_ADR, 32'h0);
    chk("af_ofs", SFC_DEF_OFS, r);
    wb(1'b0, SFC_IRQ_MK_ADR, 32'h0);
    chk("mask", {28'h0, SFC_MASK_RST}, r);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, r);
    for (int i = 0; i < 4; i++) put(i[1], i[0]);
    repeat (20) put(1'b0, 1'b1);
    wb(1'b0, SFC_STATUS_ADR, 32'h0);
    chk("count", q.size(), {27'h0, r[20:16]});
    chk("mode", 32'h0, {31'h0, r[SFC_ST_PROG]});
    wb(1'b0, SFC_IRQ_ST_ADR, 32'h0);
    chk("overflow", 32'h1, {31'h0, r[SFC_EV_OVER]});
    chk("irq_st", 32'h6, {28'h0, r[3:0]});
    wb(1'b1, SFC_IRQ_MK_ADR, 32'h4);
    @(negedge clk_i);
    chk("irq_on", 32'h1, {31'h0, irq_o});
    wb(1'b1, SFC_IRQ_ST_ADR, 32'h4);
    @(negedge clk_i);
    chk("irq_off", 32'h0, {31'h0, irq_o});
    for (int i = 3; i >= 0; i--) get(i[1], i[0]);
    repeat (20) get(1'b0, 1'b0);
    wb(1'b0, SFC_IRQ_ST_ADR, 32'h0);
    chk("underflow", 32'h1, {31'h0, r[SFC_EV_UNDER]});
    chk("empty_ev", 32'h1, {31'h0, r[SFC_EV_EMPTY]});
    repeat (60) begin
      if ($urandom % 2) put(1'b0, 1'b1);
      else get(1'b0, 1'b0);
    end
    // output drive follows the enable one cycle later
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      oe_n <= i[0];
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      chk("oe", {31'h0, !i[0]}, {31'h0, oe_o});
    end
    // offset-load mode: strap low at reset
    do_reset(1'b0);
    wb(1'b0, SFC_STATUS_ADR, 32'h0);
    chk("mode", 32'h1, {31'h0, r[SFC_ST_PROG]});
    wb(1'b1, SFC_AE_OFS_ADR, 32'h3);
    ae = 3;
    put(1'b0, 1'b0);
    u_sfc_pin_partner.set_load(1'b1);
    wb(1'b1, SFC_AE_OFS_ADR, 32'h9);
    wb(1'b0, SFC_AE_OFS_ADR, 32'h0);
    chk("ae_ofs", 32'h3, r);
    repeat (12) put(1'($urandom % 2), 1'b1);
    repeat (12) get(1'b0, 1'b0);
    stop_test();
  end
endmodule
